// [hw/mdsf_pkg.sv]
// package of constants for the driver status word block
// Notes on behaviour
// RULE1: standstill bit 31 after 2^20 idle clocks
// RULE2: current scale shown in bits 20..16
// RULE3: bit 9 follows upper comparator, stage off
// RULE4: bit 8 follows pre-warning comparator only
// RULE5: open load B bit 7, A bit 6
// RULE6: low-side short sets bit 5/4, stage off
// RULE7: ground short sets bit 3/2, stage off
// RULE8: short flags latched until driver disabled
// RULE9: separate low-side short flags per chopper mode
// RULE10: overtemp sets bit 1, waits pre-warn clear
// RULE11: bit 0 follows pre-warning threshold
// RULE12: one overtemp pair covers both bridges
// RULE13: status read-only, reserved bits read zero
package mdsf_pkg;
  // ==========================================================
  // register map
  localparam logic [6:0]  MDSF_STATUS_ADDR   = 7'h6f;
  localparam logic [31:0] MDSF_STATUS_RESET  = 32'h0000_0000;
  // ==========================================================
  // field positions
  localparam int MDSF_BIT_STANDSTILL = 31;
  localparam int MDSF_CS_HI          = 20;
  localparam int MDSF_CS_LO          = 16;
  localparam int MDSF_BIT_SHUTDOWN   = 9;
  localparam int MDSF_BIT_PREWARN    = 8;
  localparam int MDSF_BIT_OPEN_B     = 7;
  localparam int MDSF_BIT_OPEN_A     = 6;
  localparam int MDSF_BIT_LS_B       = 5;
  localparam int MDSF_BIT_LS_A       = 4;
  localparam int MDSF_BIT_GND_B      = 3;
  localparam int MDSF_BIT_GND_A      = 2;
  localparam int MDSF_BIT_OVERTEMP      = 1;
  localparam int MDSF_BIT_OVERTEMP_WARN = 0;
  // ==========================================================
  // timing
  localparam int          MDSF_STANDSTILL_CLOCKS = 1048576; // 2^20 clocks
  localparam int          MDSF_CNT_W             = 21;
  localparam logic [20:0] MDSF_STANDSTILL_CNT    = 21'h10_0000;
  localparam logic [20:0] MDSF_CNT_ZERO          = 21'h00_0000;
  localparam logic [20:0] MDSF_CNT_ONE           = 21'h00_0001;
endpackage

// [hw/mdsf_sync2.sv]
// two-flop synchroniser for a bus of asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module mdsf_sync2 #(
  parameter int W = 1
) (
  input  wire logic         mclk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // ==========================================================
  // only the second stage reads the first
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule
`default_nettype wire

// [hw/mdsf_status.sv]
// driver status word: standstill, fault latches, temperature flags, read port
`timescale 1ns/1ps
`default_nettype none
module mdsf_status (
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  // step pulse input pin
  input  wire logic       step_in,
  // analog detectors and the enable pin, asynchronous to mclk
  input  wire logic       temp_upper_in,
  input  wire logic       temp_prewarn_in,
  input  wire logic       open_load_b_in,
  input  wire logic       open_load_a_in,
  input  wire logic       lowside_short_b_in,
  input  wire logic       lowside_short_a_in,
  input  wire logic       gnd_short_b_in,
  input  wire logic       gnd_short_a_in,
  input  wire logic       enable_low_pin_in,
  // same-clock state from the regulator and config
  input  wire logic [4:0] current_scale_in,
  input  wire logic       chopper_mode_in,
  input  wire logic       drv_enable_bit_in,
  // register access port from the uart engine
  input  wire logic       reg_rd_in,
  input  wire logic       reg_wr_in,
  input  wire logic [6:0] reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  output logic [31:0]     reg_rdata_out,
  output logic            reg_rvalid_out,
  output logic            stage_enable_out,
  output logic            standstill_out
);
  import mdsf_pkg::*;

  // ==========================================================
  // pin synchronisation
  localparam int NPIN = 10;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s;
  assign pin_raw = {step_in, temp_upper_in, temp_prewarn_in, open_load_b_in,
                    open_load_a_in, lowside_short_b_in, lowside_short_a_in,
                    gnd_short_b_in, gnd_short_a_in, enable_low_pin_in};

  mdsf_sync2 #(.W(NPIN)) u_sync (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .async_in (pin_raw),
    .sync_out (pin_s)
  );

  logic step_s;
  logic t_up_s;
  logic t_pw_s;
  logic ol_b_s;
  logic ol_a_s;
  logic ls_b_s;
  logic ls_a_s;
  logic gs_b_s;
  logic gs_a_s;
  logic pin_off_s;
  assign {step_s, t_up_s, t_pw_s, ol_b_s, ol_a_s,
          ls_b_s, ls_a_s, gs_b_s, gs_a_s, pin_off_s} = pin_s;

  // ==========================================================
  // standstill detection
  logic                  step_prev_q;
  logic                  step_prev_d;
  logic [MDSF_CNT_W-1:0] idle_cnt_q;
  logic [MDSF_CNT_W-1:0] idle_cnt_d;
  logic                  stst_q;
  logic                  stst_d;
  logic                  step_edge;

  assign step_edge = step_s & ~step_prev_q;

  // counter saturates at the limit so it never wraps into a false step
  always_comb begin
    step_prev_d = step_s;
    idle_cnt_d  = idle_cnt_q;
    stst_d      = stst_q;
    if (step_edge) begin
      idle_cnt_d = MDSF_CNT_ZERO;
      stst_d     = 1'b0;                  // RULE1
    end else if (idle_cnt_q != MDSF_STANDSTILL_CNT) begin
      idle_cnt_d = idle_cnt_q + MDSF_CNT_ONE;
    end else begin
      stst_d     = 1'b1;                  // RULE1
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      step_prev_q <= 1'b0;
      idle_cnt_q  <= MDSF_CNT_ZERO;
      stst_q      <= 1'b0;
    end else begin
      step_prev_q <= step_prev_d;
      idle_cnt_q  <= idle_cnt_d;
      stst_q      <= stst_d;
    end
  end

  // ==========================================================
  // short fault latches, one low-side pair per chopper mode
  logic       drv_disabled;
  logic [1:0] ls_b_q;
  logic [1:0] ls_b_d;
  logic [1:0] ls_a_q;
  logic [1:0] ls_a_d;
  logic       gs_b_q;
  logic       gs_b_d;
  logic       gs_a_q;
  logic       gs_a_d;
  logic       mode;

  assign drv_disabled = ~drv_enable_bit_in | pin_off_s;
  assign mode         = chopper_mode_in;

  // a short seen while disabling still latches: set beats clear
  always_comb begin
    ls_b_d = drv_disabled ? 2'h0 : ls_b_q;  // RULE8
    ls_a_d = drv_disabled ? 2'h0 : ls_a_q;  // RULE8
    gs_b_d = drv_disabled ? 1'b0 : gs_b_q;  // RULE8
    gs_a_d = drv_disabled ? 1'b0 : gs_a_q;  // RULE8
    if (ls_b_s) begin
      ls_b_d[mode] = 1'b1;                  // RULE6 RULE9
    end
    if (ls_a_s) begin
      ls_a_d[mode] = 1'b1;                  // RULE6 RULE9
    end
    if (gs_b_s) begin
      gs_b_d = 1'b1;                        // RULE7
    end
    if (gs_a_s) begin
      gs_a_d = 1'b1;                        // RULE7
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ls_b_q <= 2'h0;
      ls_a_q <= 2'h0;
      gs_b_q <= 1'b0;
      gs_a_q <= 1'b0;
    end else begin
      ls_b_q <= ls_b_d;
      ls_a_q <= ls_a_d;
      gs_b_q <= gs_b_d;
      gs_a_q <= gs_a_d;
    end
  end

  // ==========================================================
  // overtemperature: one flag pair for both bridges
  logic overtemp_q;
  logic overtemp_d;

  // stays set until pre-warning comparator has dropped too
  always_comb begin
    overtemp_d = overtemp_q;
    if (t_up_s) begin
      overtemp_d = 1'b1;                    // RULE10 RULE12
    end else if (!t_pw_s) begin
      overtemp_d = 1'b0;                    // RULE10
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      overtemp_q <= 1'b0;
    end else begin
      overtemp_q <= overtemp_d;
    end
  end

  // ==========================================================
  // power stage enable
  logic stage_q;
  logic stage_d;
  logic fault_any;

  assign fault_any = (|ls_b_d[mode]) | ls_a_d[mode] | gs_b_d | gs_a_d;

  // pre-warning alone never switches the bridge off
  always_comb begin
    stage_d = ~drv_disabled & ~fault_any   // RULE6 RULE7
            & ~t_up_s & ~overtemp_d;       // RULE3 RULE10 RULE4
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      stage_q <= 1'b0;
    end else begin
      stage_q <= stage_d;
    end
  end

  // ==========================================================
  // status word assembly
  logic [31:0] status_word;

  always_comb begin
    status_word = MDSF_STATUS_RESET;                        // RULE13
    status_word[MDSF_BIT_STANDSTILL]     = stst_q;          // RULE1
    status_word[MDSF_CS_HI:MDSF_CS_LO]   = current_scale_in; // RULE2
    status_word[MDSF_BIT_SHUTDOWN]       = t_up_s;          // RULE3
    status_word[MDSF_BIT_PREWARN]        = t_pw_s;          // RULE4
    status_word[MDSF_BIT_OPEN_B]         = ol_b_s;          // RULE5
    status_word[MDSF_BIT_OPEN_A]         = ol_a_s;          // RULE5
    status_word[MDSF_BIT_LS_B]           = ls_b_q[mode];    // RULE6 RULE9
    status_word[MDSF_BIT_LS_A]           = ls_a_q[mode];    // RULE6 RULE9
    status_word[MDSF_BIT_GND_B]          = gs_b_q;          // RULE7
    status_word[MDSF_BIT_GND_A]          = gs_a_q;          // RULE7
    status_word[MDSF_BIT_OVERTEMP]       = overtemp_q;      // RULE10 RULE12
    status_word[MDSF_BIT_OVERTEMP_WARN]  = t_pw_s;          // RULE11 RULE12
  end

  // ==========================================================
  // read port; writes are dropped, other addresses read zero
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        rvalid_q;
  logic        rvalid_d;

  always_comb begin
    rdata_d  = rdata_q;
    rvalid_d = 1'b0;
    if (reg_rd_in && reg_addr_in == MDSF_STATUS_ADDR) begin
      rdata_d  = status_word;
      rvalid_d = 1'b1;
    end else if (reg_rd_in) begin
      rdata_d  = MDSF_STATUS_RESET;
      rvalid_d = 1'b1;
    end
    // reg_wr_in and reg_wdata_in have no effect here   // RULE13
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      rdata_q  <= MDSF_STATUS_RESET;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  logic unused_wr;
  assign unused_wr = reg_wr_in ^ (^reg_wdata_in);

  assign reg_rdata_out    = rdata_q;
  assign reg_rvalid_out   = rvalid_q;
  assign stage_enable_out = stage_q;
  assign standstill_out   = stst_q;
endmodule
`default_nettype wire

// [tb/mdsf_status_asserts.sv]
// checker for the driver status word ports
`timescale 1ns/1ps
`default_nettype none
module mdsf_status_asserts (
  input wire logic        mclk_in,
  input wire logic        rst_n_in,
  input wire logic        step_in,
  input wire logic        temp_upper_in,
  input wire logic        lowside_short_b_in,
  input wire logic        lowside_short_a_in,
  input wire logic        gnd_short_b_in,
  input wire logic        gnd_short_a_in,
  input wire logic        enable_low_pin_in,
  input wire logic [4:0]  current_scale_in,
  input wire logic        reg_rd_in,
  input wire logic        reg_wr_in,
  input wire logic [6:0]  reg_addr_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic        reg_rvalid_out,
  input wire logic        stage_enable_out,
  input wire logic        standstill_out
);
  // ==========================================================
  // read port
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  rvalid_pulse_a: assert property (reg_rd_in |=> reg_rvalid_out) else $error("no read answer");
  rvalid_only_a: assert property (!reg_rd_in |=> !reg_rvalid_out) else $error("stray answer");
  reserved_zero_a: assert property (reg_rvalid_out |->
    reg_rdata_out[30:21] == 10'h000 && reg_rdata_out[15:10] == 6'h00) else $error("reserved set");
  unmapped_zero_a: assert property (reg_rd_in && reg_addr_in != 7'h6f
    |=> reg_rdata_out == 32'h0000_0000) else $error("unmapped nonzero");
  scale_field_a: assert property (reg_rd_in && reg_addr_in == 7'h6f
    |=> reg_rdata_out[20:16] == $past(current_scale_in)) else $error("scale field wrong");
  // ==========================================================
  // power stage; pins pass a two-flop sync, so three samples
  short_stage_a: assert property ((lowside_short_b_in || lowside_short_a_in ||
    gnd_short_b_in || gnd_short_a_in)[*3] |=> !stage_enable_out) else $error("stage on at short");
  upper_stage_a: assert property (temp_upper_in[*3] |=> !stage_enable_out)
    else $error("stage on when hot");
  pin_stage_a: assert property (enable_low_pin_in[*3] |=> !stage_enable_out)
    else $error("stage on when pin off");
  step_clear_a: assert property ($rose(step_in) |-> ##[1:5] !standstill_out)
    else $error("standstill not cleared");
  // ==========================================================
  // idle clocks since the last step edge on the pin, saturating at the limit
  logic        step_prev_q;
  logic [20:0] idle_cyc_q;
  always_ff @(posedge mclk_in) begin
    step_prev_q <= step_in;
    if (!rst_n_in || (step_in && !step_prev_q)) begin
      idle_cyc_q <= 21'h00_0000;
    end else if (idle_cyc_q != 21'h10_0000) begin
      idle_cyc_q <= idle_cyc_q + 21'h00_0001;
    end
  end
  // the pin leads the design by the sync delay, so the limit is reached first
  standstill_early_a: assert property ($rose(standstill_out) |-> idle_cyc_q == 21'h10_0000)
    else $error("standstill too early");
  cover property (reg_rvalid_out && reg_rdata_out[5]);
  cover property (reg_rvalid_out && reg_rdata_out[1]);
  cover property (reg_wr_in);
endmodule
bind mdsf_status mdsf_status_asserts chk_u (.mclk_in, .rst_n_in, .step_in, .temp_upper_in,
  .lowside_short_b_in, .lowside_short_a_in, .gnd_short_b_in, .gnd_short_a_in,
  .enable_low_pin_in, .current_scale_in, .reg_rd_in, .reg_wr_in, .reg_addr_in,
  .reg_rdata_out, .reg_rvalid_out, .stage_enable_out, .standstill_out);
`default_nettype wire

// [tb/mdsf_host.sv]
// host model: status reads, ignored writes, driver disable
`timescale 1ns/1ps
`default_nettype none
module mdsf_host (
  input  wire logic        mclk_in,
  input  wire logic        rvalid_in,
  input  wire logic [31:0] rdata_in,
  output logic             rd_out,
  output logic             wr_out,
  output logic [6:0]       addr_out,
  output logic             en_out,
  output logic             pin_out
);
  // idle: enabled, address shows junk when unused
  initial begin
    rd_out = 1'b0;
    wr_out = 1'b0;
    addr_out = 7'h55;
    en_out = 1'b1;
    pin_out = 1'b0;
  end
  // strobe held across one rising edge, answer waited for a bounded time
  task automatic rd(input logic [6:0] a, output logic [31:0] d, output logic ok);
    int n;
    @(negedge mclk_in);
    rd_out = 1'b1;
    addr_out = a;
    @(negedge mclk_in);
    rd_out = 1'b0;
    addr_out = ~a;
    n = 0;
    while (rvalid_in !== 1'b1 && n < 4) begin
      @(negedge mclk_in);
      n++;
    end
    ok = (n < 4);
    d = rdata_in;
  endtask
  task automatic wr(input logic [6:0] a);
    @(negedge mclk_in);
    wr_out = 1'b1;
    addr_out = a;
    @(negedge mclk_in);
    wr_out = 1'b0;
    addr_out = ~a;
  endtask
  // latched shorts only clear while the driver is off
  task automatic clear(input logic by_pin);
    @(negedge mclk_in);
    if (by_pin) pin_out = 1'b1;
    else en_out = 1'b0;
    repeat (4) @(negedge mclk_in);
    pin_out = 1'b0;
    en_out = 1'b1;
  endtask
endmodule
`default_nettype wire

// [tb/motor_driver_status_flags_tb.sv]
// self-checking bench for the driver status word
`timescale 1ns/1ps
`default_nettype none
module motor_driver_status_flags_tb;
  import mdsf_pkg::*;
  logic        clk, rst_n, step, tu, tp, olb, ola, mode, rd, wr, en, pin, rvalid, stage, stand;
  logic [3:0]  sh;
  logic [4:0]  cs;
  logic [6:0]  addr;
  logic [31:0] rdata;
  int          n_mismatch = 0;
  int          checks_done = 0;
  // ==========================================================
  // design and host
  mdsf_status dut_u (.mclk_in(clk), .rst_n_in(rst_n), .step_in(step), .temp_upper_in(tu),
    .temp_prewarn_in(tp), .open_load_b_in(olb), .open_load_a_in(ola),
    .lowside_short_b_in(sh[3]), .lowside_short_a_in(sh[2]), .gnd_short_b_in(sh[1]),
    .gnd_short_a_in(sh[0]), .enable_low_pin_in(pin), .current_scale_in(cs),
    .chopper_mode_in(mode), .drv_enable_bit_in(en), .reg_rd_in(rd), .reg_wr_in(wr),
    .reg_addr_in(addr), .reg_wdata_in(32'hffff_ffff), .reg_rdata_out(rdata),
    .reg_rvalid_out(rvalid), .stage_enable_out(stage), .standstill_out(stand));
  mdsf_host host_u (.mclk_in(clk), .rvalid_in(rvalid), .rdata_in(rdata), .rd_out(rd),
    .wr_out(wr), .addr_out(addr), .en_out(en), .pin_out(pin));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ==========================================================
  // checking helpers
  task automatic report_and_stop();
    if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // let the two-flop syncs settle, then read; scale field is always live
  task automatic expect_status(input logic [31:0] flags, input logic st_en);
    logic [31:0] d;
    logic        ok;
    repeat (5) @(negedge clk);
    host_u.rd(MDSF_STATUS_ADDR, d, ok);
    if (!ok) begin
      n_mismatch++;
      report_and_stop();
    end
    chk(d, flags | {11'h000, cs, 16'h0000});
    chk({31'h0, stage}, {31'h0, st_en});
    chk({31'h0, stand}, {31'h0, flags[31]});
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs();
    logic [31:0] d;
    logic        ok;
    step = 1'b1;
    expect_status(32'h0, 1'b1);
    host_u.wr(MDSF_STATUS_ADDR);
    cs = 5'h0a;
    expect_status(32'h0, 1'b1);
    host_u.rd(7'h70, d, ok);
    chk(d, 32'h0);
    chk({31'h0, ok}, 32'h1);
  endtask
  task automatic t_temp();
    tp = 1'b1;
    expect_status(32'h0000_0101, 1'b1);
    tu = 1'b1;
    expect_status(32'h0000_0303, 1'b0);
    tu = 1'b0;
    expect_status(32'h0000_0103, 1'b0);
    tp = 1'b0;
    expect_status(32'h0, 1'b1);
    olb = 1'b1;
    ola = 1'b1;
    expect_status(32'h0000_00c0, 1'b1);
    olb = 1'b0;
    ola = 1'b0;
  endtask
  // each short pulsed briefly, must stay latched until a disable
  task automatic t_short();
    for (int i = 0; i < 4; i++) begin
      sh = 4'(4'h1 << i);
      repeat (3) @(negedge clk);
      sh = 4'h0;
      expect_status(32'h4 << i, 1'b0);
      host_u.clear(i[0]);
      expect_status(32'h0, 1'b1);
    end
    sh = 4'h4;
    repeat (3) @(negedge clk);
    sh = 4'h0;
    expect_status(32'h0000_0010, 1'b0);
    mode = 1'b1;
    expect_status(32'h0, 1'b1);
    mode = 1'b0;
    expect_status(32'h0000_0010, 1'b0);
    mode = 1'b1;
    sh = 4'h8;
    repeat (3) @(negedge clk);
    sh = 4'h0;
    expect_status(32'h0000_0020, 1'b0);
    mode = 1'b0;
    expect_status(32'h0000_0010, 1'b0);
    host_u.clear(1'b0);
    expect_status(32'h0, 1'b1);
    mode = 1'b1;
    expect_status(32'h0, 1'b1);
    mode = 1'b0;
  endtask
  // a mid-run reset must drop a latched ground short
  task automatic t_reset();
    sh = 4'h1;
    repeat (3) @(negedge clk);
    sh = 4'h0;
    expect_status(32'h0000_0004, 1'b0);
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    expect_status(32'h0, 1'b1);
  endtask
  initial begin
    {rst_n, step, tu, tp, olb, ola, mode} = 7'h00;
    sh = 4'h0;
    cs = 5'h15;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    t_regs();
    t_temp();
    t_short();
    t_reset();
    report_and_stop();
  end
endmodule
`default_nettype wire
